// ### inc/exc_pkg.sv
// Shared constants and types for the exception entry and context unit.
// Assumes a 32-bit core whose pipeline reports causes as one bit per cause.
package exc_pkg;

  localparam int CAUSE_N = 15;
  localparam int CID_W = 4;
  localparam int N_CTX = 16;

  // Cause codes in priority order: among enabled causes a lower code wins
  typedef enum logic [3:0] {
    C_RESET = 4'h0,
    C_ITLB = 4'h1,
    C_IPF = 4'h2,
    C_IBUS = 4'h3,
    C_ILLEGAL = 4'h4,
    C_ALIGN = 4'h5,
    C_DTLB = 4'h6,
    C_SYSCALL = 4'h7,
    C_TRAP = 4'h8,
    C_DPF = 4'h9,
    C_DBUS = 4'hA,
    C_RANGE = 4'hB,
    C_FP = 4'hC,
    C_TICK = 4'hD,
    C_EXT = 4'hE
  } cause_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FP_WAIT = 2'b10
  } exc_state_t;

  // Supervision register fields
  localparam int SR_SM = 0;
  localparam int SR_TEE = 1;
  localparam int SR_IEE = 2;
  localparam int SR_DME = 5;
  localparam int SR_IME = 6;
  localparam int SR_CE = 12;
  localparam int SR_DSX = 13;
  localparam int SR_CID_LSB = 28;
  localparam int SR_CID_MSB = 31;
  localparam logic [31:0] SR_RESET = 32'h0000_0001;

  // Context register fields
  localparam int CXR_CURRENT_CONTEXT_ID_LSB = 16;
  localparam int CXR_CURRENT_CONTEXT_ID_MSB = 31;
  localparam int CXR_CONTEXT_REG_SET_LSB = 0;
  localparam int CXR_CONTEXT_REG_SET_MSB = 15;
  localparam logic [15:0] CONTEXT_REG_SET_RESET = 16'h0000;

  // Special-register addresses
  localparam logic [15:0] SPR_SR = 16'h0011;
  localparam logic [15:0] SPR_EXCEPTION_PC_REG = 16'h0020;
  localparam logic [15:0] SPR_EXCEPTION_ADDR_REG = 16'h0030;
  localparam logic [15:0] SPR_ESR = 16'h0040;
  localparam logic [15:0] SPR_CXR = 16'h0080;

  localparam logic [31:0] PC_STEP = 32'h0000_0004;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Vector offsets per cause
  localparam logic [31:0] VEC_RESET = 32'h0000_0100;
  localparam logic [31:0] VEC_BUS = 32'h0000_0200;
  localparam logic [31:0] VEC_DPF = 32'h0000_0300;
  localparam logic [31:0] VEC_IPF = 32'h0000_0400;
  localparam logic [31:0] VEC_TICK = 32'h0000_0500;
  localparam logic [31:0] VEC_ALIGN = 32'h0000_0600;
  localparam logic [31:0] VEC_ILLEGAL = 32'h0000_0700;
  localparam logic [31:0] VEC_EXT = 32'h0000_0800;
  localparam logic [31:0] VEC_DTLB = 32'h0000_0900;
  localparam logic [31:0] VEC_ITLB = 32'h0000_0A00;
  localparam logic [31:0] VEC_RANGE = 32'h0000_0B00;
  localparam logic [31:0] VEC_SYSCALL = 32'h0000_0C00;
  localparam logic [31:0] VEC_FP = 32'h0000_0D00;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0E00;

  function automatic logic [31:0] vector_of(input cause_t c);
    logic [31:0] v;
    v = VEC_RESET;
    unique case (c)
      C_RESET: v = VEC_RESET;
      C_ITLB: v = VEC_ITLB;
      C_IPF: v = VEC_IPF;
      C_IBUS: v = VEC_BUS;
      C_ILLEGAL: v = VEC_ILLEGAL;
      C_ALIGN: v = VEC_ALIGN;
      C_DTLB: v = VEC_DTLB;
      C_SYSCALL: v = VEC_SYSCALL;
      C_TRAP: v = VEC_TRAP;
      C_DPF: v = VEC_DPF;
      C_DBUS: v = VEC_BUS;
      C_RANGE: v = VEC_RANGE;
      C_FP: v = VEC_FP;
      C_TICK: v = VEC_TICK;
      C_EXT: v = VEC_EXT;
      default: v = VEC_RESET;
    endcase
    return v;
  endfunction

  // Causes that report an effective address
  function automatic logic loads_ea(input cause_t c);
    return (c == C_IBUS) || (c == C_DBUS) || (c == C_IPF) || (c == C_DPF) ||
           (c == C_ALIGN) || (c == C_ITLB) || (c == C_DTLB);
  endfunction

  // Causes that resume at the next unexecuted instruction
  function automatic logic resumes_next(input cause_t c);
    return (c == C_TICK) || (c == C_EXT) || (c == C_SYSCALL) || (c == C_FP);
  endfunction

endpackage

// ### hw/exc_arbiter.sv
// Fixed-priority picker over the pending exception causes.
// Assumes bit 0 is the most urgent cause.
`timescale 1ns/1ps
module exc_arbiter #(
  parameter int N = 15,
  parameter int IDX_W = 4
) (
  input logic [N-1:0] req,
  output logic any,
  output logic [IDX_W-1:0] idx,
  output logic [N-1:0] grant
);

  always_comb
  begin
    any = 1'b0;
    idx = '0;
    grant = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = IDX_W'(i);
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

endmodule

// ### hw/exc_unit.sv
// Exception entry, return and fast context switch for the core.
// Assumes the pipeline holds each cause and its addresses until acknowledged,
// and keeps fp_wb_done low until the faulting FP result is written back.
`timescale 1ns/1ps

// Behaviour
// - Every exception except reset saves the current or next PC into the active context's slot.
// - Delay slot with delay slots enabled saves PC minus four and sets delay flag.
// - Supervision register is copied into the active context's status slot.
// - Slots are indexed by context id; set zero when fast switching is absent.
// - Address faults, misses and bus errors load the faulting virtual address.
// - Floating point exceptions wait for register writeback before redirecting.
// - Causes are ranked by the fixed priority order from reset to interrupts.
// - Faults and traps save the faulting address, or the preceding jump.
// - Interrupts, syscalls and FP save the next instruction, or the jump.
// - With fast switching each new exception uses a fresh shadow set.
// - If the context id would overflow, a range exception is raised instead.
// - With context enable clear, no switching and the selection never advances.
// - Entry sets supervisor mode, disables translation, interrupts and tick.
// - Return restores supervision and PC; context enable steps the id back.
// - Context register: current id in 31-16, register set in 15-0, reset zero.
// - Context register and current id are refused in user mode.
// - Writing the current id switches at once; reading returns the running id.
// - On switching exception, current id goes to register set, then to zero.
// - Register set field picks whose shadow registers the special moves reach.
// - A context switch completes in one clock cycle.
// - One context register is shared by all contexts.
// - After saving, PC is loaded with the winning cause's vector offset.
module exc_unit
  import exc_pkg::*;
#(
  parameter bit FAST_CTX = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [exc_pkg::CAUSE_N-1:0] cause_req,
  output logic [exc_pkg::CAUSE_N-1:0] cause_ack,
  input wire logic [31:0] insn_pc,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] fault_ea,
  input wire logic in_delay_slot,
  input wire logic no_delay_slot_flag,
  input wire logic fp_wb_done,
  input wire logic rfe_req,
  output logic exc_stall,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [31:0] supervision_reg,
  input wire logic spr_re,
  input wire logic spr_we,
  input wire logic [15:0] spr_addr,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  output logic spr_err
);
  import exc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  exc_state_t state_q;
  exc_state_t state_d;
  logic [31:0] supervision_reg_q;
  logic [31:0] supervision_reg_d;
  logic [31:0] exception_pc_reg_q [N_CTX];
  logic [31:0] exception_status_reg_q [N_CTX];
  logic [31:0] exception_addr_reg_q [N_CTX];
  logic [15:0] context_reg_set_q;
  logic [15:0] context_reg_set_d;
  logic redirect_valid_q;
  logic [31:0] redirect_pc_q;
  logic [31:0] spr_rdata_q;
  logic spr_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cause selection

  logic [CAUSE_N-1:0] req_gated;
  logic win_any;
  logic [3:0] win_idx;
  logic [CAUSE_N-1:0] win_grant;

  always_comb
  begin
    req_gated = cause_req;
    req_gated[C_TICK] = cause_req[C_TICK] & supervision_reg_q[SR_TEE];
    req_gated[C_EXT] = cause_req[C_EXT] & supervision_reg_q[SR_IEE];
  end

  exc_arbiter #(
    .N(CAUSE_N),
    .IDX_W(4)
  ) u_arb (
    .req(req_gated),
    .any(win_any),
    .idx(win_idx),
    .grant(win_grant)
  );

  wire [CID_W-1:0] context_id = supervision_reg_q[SR_CID_MSB:SR_CID_LSB];
  // Switching needs both the build option and the enable bit
  wire ctx_on = FAST_CTX & supervision_reg_q[SR_CE];
  wire cid_full = (context_id == {CID_W{1'b1}});
  wire is_reset = win_any && (cause_t'(win_idx) == C_RESET);
  // No fresh set left: turn the cause into a range exception
  wire cid_ovf = win_any && ctx_on && cid_full && !is_reset;
  wire cause_t take_cause = cid_ovf ? C_RANGE : cause_t'(win_idx);
  // FP results must land before the vector fetch
  wire fp_hold = win_any && (take_cause == C_FP) && !fp_wb_done;
  wire take = win_any && !fp_hold;
  wire rfe_take = rfe_req && !win_any;

  // Others stay raised at the pipeline until their own turn
  assign cause_ack = take ? win_grant : '0;
  assign exc_stall = fp_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Saved values

  // Fresh set is one past the interrupted context; overflow reuses the last
  wire [CID_W-1:0] cid_next = context_id + CID_W'(1);
  wire [CID_W-1:0] save_idx = !ctx_on ? '0 : (cid_ovf ? context_id : cid_next);
  wire [31:0] base_pc = resumes_next(take_cause) ? next_pc : insn_pc;
  wire in_ds = in_delay_slot && !no_delay_slot_flag;
  wire [31:0] saved_pc = in_ds ? (base_pc - PC_STEP) : base_pc;

  logic [31:0] entry_sr;
  always_comb
  begin
    entry_sr = supervision_reg_q;
    entry_sr[SR_SM] = 1'b1;
    entry_sr[SR_DME] = 1'b0;
    entry_sr[SR_IME] = 1'b0;
    entry_sr[SR_IEE] = 1'b0;
    entry_sr[SR_TEE] = 1'b0;
    entry_sr[SR_DSX] = in_ds;
    if (ctx_on)
    begin
      entry_sr[SR_CID_MSB:SR_CID_LSB] = '0;
    end
  end

  // Return reads the set the handler was entered through
  wire [CID_W-1:0] context_reg_set_idx = context_reg_set_q[CID_W-1:0];
  wire [CID_W-1:0] ret_idx = ctx_on ? (context_reg_set_idx + CID_W'(1)) : '0;
  logic [31:0] ret_sr;
  always_comb
  begin
    ret_sr = exception_status_reg_q[ret_idx];
    if (ctx_on)
    begin
      ret_sr[SR_CID_MSB:SR_CID_LSB] = ret_idx - CID_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special-register port

  wire user_mode = !supervision_reg_q[SR_SM];
  wire sel_sr = (spr_addr == SPR_SR);
  wire sel_exception_pc_reg = (spr_addr == SPR_EXCEPTION_PC_REG);
  wire sel_exception_addr_reg = (spr_addr == SPR_EXCEPTION_ADDR_REG);
  wire sel_esr = (spr_addr == SPR_ESR);
  wire sel_cxr = (spr_addr == SPR_CXR);
  wire sel_any = sel_sr | sel_exception_pc_reg | sel_exception_addr_reg | sel_esr | sel_cxr;
  wire acc = spr_re | spr_we;
  // User code reaches none of these; context register above all
  wire acc_bad = acc && (user_mode || !sel_any);
  wire wr_ok = spr_we && !acc_bad;
  // Exception entry and return own the state in their cycle
  wire wr_live = wr_ok && !take && !rfe_take;

  wire [31:0] cxr_view = {{(16 - CID_W){1'b0}}, context_id, context_reg_set_q};

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (sel_sr)
    begin
      rd_mux = supervision_reg_q;
    end
    if (sel_exception_pc_reg)
    begin
      rd_mux = exception_pc_reg_q[context_reg_set_idx];
    end
    if (sel_exception_addr_reg)
    begin
      rd_mux = exception_addr_reg_q[context_reg_set_idx];
    end
    if (sel_esr)
    begin
      rd_mux = exception_status_reg_q[context_reg_set_idx];
    end
    if (sel_cxr)
    begin
      rd_mux = cxr_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    supervision_reg_d = supervision_reg_q;
    context_reg_set_d = context_reg_set_q;
    if (take)
    begin
      if (!is_reset)
      begin
        supervision_reg_d = entry_sr;
        if (ctx_on && !cid_ovf)
        begin
          context_reg_set_d = {{(16 - CID_W){1'b0}}, context_id};
        end
      end
    end
    else if (rfe_take)
    begin
      supervision_reg_d = ret_sr;
    end
    else if (wr_live && sel_sr)
    begin
      supervision_reg_d = spr_wdata;
    end
    else if (wr_live && sel_cxr)
    begin
      // Id change is visible the very next cycle
      supervision_reg_d[SR_CID_MSB:SR_CID_LSB] =
        spr_wdata[CXR_CURRENT_CONTEXT_ID_LSB +: CID_W];
      context_reg_set_d = spr_wdata[CXR_CONTEXT_REG_SET_MSB:CXR_CONTEXT_REG_SET_LSB];
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (fp_hold)
        begin
          state_d = ST_FP_WAIT;
        end
      ST_FP_WAIT:
        if (!fp_hold)
        begin
          state_d = ST_IDLE;
        end
      default:
        state_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      supervision_reg_q <= SR_RESET;
      context_reg_set_q <= CONTEXT_REG_SET_RESET;
      redirect_valid_q <= 1'b0;
      redirect_pc_q <= WORD_RESET;
      spr_rdata_q <= WORD_RESET;
      spr_err_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      supervision_reg_q <= supervision_reg_d;
      context_reg_set_q <= context_reg_set_d;
      redirect_valid_q <= take || rfe_take;
      if (take)
      begin
        redirect_pc_q <= vector_of(take_cause);
      end
      else if (rfe_take)
      begin
        redirect_pc_q <= exception_pc_reg_q[ret_idx];
      end
      spr_err_q <= acc_bad;
      if (spr_re && !acc_bad)
      begin
        spr_rdata_q <= rd_mux;
      end
    end
  end

  // Shadow sets clear with the core reset so a stray return reads zeros
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < N_CTX; i++)
      begin
        exception_pc_reg_q[i] <= WORD_RESET;
        exception_status_reg_q[i] <= WORD_RESET;
        exception_addr_reg_q[i] <= WORD_RESET;
      end
    end
    else if (take && !is_reset)
    begin
      exception_pc_reg_q[save_idx] <= saved_pc;
      exception_status_reg_q[save_idx] <= supervision_reg_q;
      if (loads_ea(take_cause))
      begin
        exception_addr_reg_q[save_idx] <= fault_ea;
      end
    end
    else if (wr_live && sel_exception_pc_reg)
    begin
      exception_pc_reg_q[context_reg_set_idx] <= spr_wdata;
    end
    else if (wr_live && sel_exception_addr_reg)
    begin
      exception_addr_reg_q[context_reg_set_idx] <= spr_wdata;
    end
    else if (wr_live && sel_esr)
    begin
      exception_status_reg_q[context_reg_set_idx] <= spr_wdata;
    end
  end

  assign redirect_valid = redirect_valid_q;
  assign redirect_pc = redirect_pc_q;
  assign supervision_reg = supervision_reg_q;
  assign spr_rdata = spr_rdata_q;
  assign spr_err = spr_err_q;

endmodule

// ### test/pipe_model.sv
// Pipeline stand-in that posts exception causes to the unit.
// Assumes post and post_bits change just after a rising edge.
`timescale 1ns/1ps
module pipe_model
  import exc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic post,
  input wire logic [exc_pkg::CAUSE_N-1:0] post_bits,
  input wire logic [exc_pkg::CAUSE_N-1:0] cause_ack,
  output logic [exc_pkg::CAUSE_N-1:0] cause_req
);
  logic [CAUSE_N-1:0] req_q;
  logic [CAUSE_N-1:0] req_d;
  // Held until acknowledged, so a losing cause is never lost
  assign req_d = (req_q & ~cause_ack) | (post ? post_bits : '0);
  assign cause_req = req_q;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      req_q <= '0;
    else
      req_q <= req_d;
endmodule

// ### test/exc_unit_properties.sv
// Concurrent checks on the ports of the exception unit.
// Assumes one clock domain; bound to every exc_unit instance.
`timescale 1ns/1ps
module exc_unit_checker
  import exc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [exc_pkg::CAUSE_N-1:0] cause_req,
  input wire logic [exc_pkg::CAUSE_N-1:0] cause_ack,
  input wire logic [31:0] insn_pc,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] fault_ea,
  input wire logic in_delay_slot,
  input wire logic no_delay_slot_flag,
  input wire logic fp_wb_done,
  input wire logic rfe_req,
  input wire logic exc_stall,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic [31:0] supervision_reg,
  input wire logic spr_re,
  input wire logic spr_we,
  input wire logic [15:0] spr_addr,
  input wire logic [31:0] spr_wdata,
  input wire logic [31:0] spr_rdata,
  input wire logic spr_err
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // No fresh set left: any winner except reset is turned into a range exception
  wire ovf_now = supervision_reg[SR_CE] && (supervision_reg[SR_CID_MSB:SR_CID_LSB] == 4'hF);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_taken;
    cause_ack[14:1] != 14'h0 ##1 redirect_valid;
  endsequence
  property p_one_hot;
    $onehot0(cause_ack);
  endproperty
  property p_prio;
    cause_ack != '0 |->
      (cause_req & (cause_ack - 15'h1) & ~{1'b0, !supervision_reg[SR_TEE], 13'h0}) == '0;
  endproperty
  property p_vec_align;
    cause_ack[C_ALIGN] && !ovf_now |=> redirect_valid && redirect_pc == VEC_ALIGN;
  endproperty
  property p_vec_dbus;
    cause_ack[C_DBUS] && !ovf_now |=> redirect_valid && redirect_pc == VEC_BUS;
  endproperty
  property p_sr_entry;
    s_taken |-> (supervision_reg & 32'h0000_0067) == 32'h0000_0001;
  endproperty
  property p_fp_wait;
    cause_req[11:0] == '0 && cause_req[C_FP] && !fp_wb_done && !ovf_now |->
      exc_stall && !cause_ack[C_FP];
  endproperty
  property p_user_err;
    (spr_re || spr_we) && !supervision_reg[SR_SM] && cause_ack == '0 && !rfe_req |=> spr_err;
  endproperty
  property p_rfe;
    rfe_req && cause_req == '0 |=> redirect_valid;
  endproperty
  property p_quiet;
    !rfe_req && cause_ack == '0 |=> !redirect_valid;
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("two causes taken");
  a_prio: assert property (p_prio) else $error("lower cause passed over");
  a_vec_align: assert property (p_vec_align) else $error("align vector wrong");
  a_vec_dbus: assert property (p_vec_dbus) else $error("bus vector wrong");
  a_sr_entry: assert property (p_sr_entry) else $error("entry state wrong");
  a_fp_wait: assert property (p_fp_wait) else $error("fp taken early");
  a_user_err: assert property (p_user_err) else $error("user access allowed");
  a_rfe: assert property (p_rfe) else $error("return not redirected");
  a_quiet: assert property (p_quiet) else $error("redirect without cause");
endmodule

bind exc_unit exc_unit_checker i_chk(.clk_sys, .rst_b, .cause_req, .cause_ack, .insn_pc,
  .next_pc, .fault_ea, .in_delay_slot, .no_delay_slot_flag, .fp_wb_done, .rfe_req,
  .exc_stall, .redirect_valid, .redirect_pc, .supervision_reg, .spr_re, .spr_we, .spr_addr,
  .spr_wdata, .spr_rdata, .spr_err);

// ### test/exception_entry_and_context_switch_test.sv
// Self-checking bench for the exception entry and context unit.
// Assumes exc_pkg, pipe_model and the bound checker are compiled first.
`timescale 1ns/1ps
module exception_entry_and_context_switch_test;
  import exc_pkg::*;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
  logic clk_sys = 1'b0, rst_b = 1'b0, post = 1'b0, ds = 1'b0, nd = 1'b0, fpw = 1'b1;
  logic rfe = 1'b0, re = 1'b0, we = 1'b0, stall, rv, err;
  logic [14:0] bits = 15'h0, req, ack;
  logic [15:0] adr = 16'h0;
  logic [31:0] ipc = 32'h0, npc = 32'h0, ea = 32'h0, wd = 32'h0, rpc, sr, rd;
  logic [31:0] msr = 32'h0000_0001, mpc, psr, mea = 32'h0;
  logic [11:0] vec [15] = '{12'h100, 12'hA00, 12'h400, 12'h200, 12'h700, 12'h600, 12'h900,
    12'hC00, 12'hE00, 12'h300, 12'h200, 12'hB00, 12'hD00, 12'h500, 12'h800};
  int n_fail = 0, compares = 0, cyc = 0, a, b;

  pipe_model i_pipe(.clk_sys, .rst_b, .post, .post_bits(bits), .cause_ack(ack), .cause_req(req));
  exc_unit #(.FAST_CTX(1'b1)) i_dut(.clk_sys, .rst_b, .cause_req(req), .cause_ack(ack),
    .insn_pc(ipc), .next_pc(npc), .fault_ea(ea), .in_delay_slot(ds), .no_delay_slot_flag(nd),
    .fp_wb_done(fpw), .rfe_req(rfe), .exc_stall(stall), .redirect_valid(rv), .redirect_pc(rpc),
    .supervision_reg(sr), .spr_re(re), .spr_we(we), .spr_addr(adr), .spr_wdata(wd),
    .spr_rdata(rd), .spr_err(err));

  initial
    forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_rv();
    for (int k = 0; k < 9; k++)
    begin
      #1;
      if (rv === 1'b1)
        return;
      @(posedge clk_sys);
    end
    n_fail++;
    $display("[FAIL] redirect exp 1 got 0");
  endtask
  task automatic spr(input logic w, input logic [15:0] a_i, input logic [31:0] d);
    @(posedge clk_sys);
    {re, we, adr, wd} <= {!w, w, a_i, d};
    @(posedge clk_sys);
    {re, we} <= 2'b00;
    #1;
  endtask
  task automatic set_sr(input logic [31:0] v);
    spr(1'b1, SPR_SR, v);
    msr = v;
  endtask
  task automatic ret();
    @(posedge clk_sys);
    rfe <= 1'b1;
    @(posedge clk_sys);
    rfe <= 1'b0;
    wait_rv();
  endtask
  // Raise one cause with random addresses, then check vector, state and, with context enable clear, saved copies
  task automatic take(input int c);
    logic [31:0] p, n, e, s;
    logic d, x;
    p = $urandom & 32'hFFFF_FFFC;
    n = p + 32'h0000_0004;
    e = $urandom;
    d = 1'($urandom);
    x = 1'($urandom);
    @(posedge clk_sys);
    {ipc, npc, ea, ds, nd, bits, post} <= {p, n, e, d, x, 15'(1) << c, 1'b1};
    fpw <= (c != 12);
    @(posedge clk_sys);
    post <= 1'b0;
    if (c == 12)
    begin
      repeat (3)
      begin
        #1;
        `CHK("fp stall", 1'b1, stall)
        `CHK("fp held", 1'b0, rv)
        @(posedge clk_sys);
      end
      fpw <= 1'b1;
    end
    wait_rv();
    if (msr[12] && msr[31:28] == 4'hF)
      c = 11;
    `CHK("vector", {20'h0, vec[c]}, rpc)
    if (c inside {7, 12, 13, 14})
      p = n;
    if (d && !x)
      p = p - 32'h0000_0004;
    s = (msr & (msr[12] ? 32'h0FFF_DF98 : 32'hFFFF_DF98)) | {18'h0, d && !x, 12'h0, 1'b1};
    `CHK("sr entry", s, sr)
    psr = msr;
    msr = s;
    mpc = p;
    if (c inside {1, 2, 3, 5, 6, 9, 10})
      mea = e;
    if (!psr[12])
    begin
      spr(1'b0, SPR_EXCEPTION_PC_REG, 32'h0);
      `CHK("saved pc", p, rd)
      spr(1'b0, SPR_EXCEPTION_ADDR_REG, 32'h0);
      `CHK("fault addr", mea, rd)
      spr(1'b0, SPR_ESR, 32'h0);
      `CHK("saved sr", psr, rd)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(13985));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    spr(1'b0, SPR_CXR, 32'h0);
    `CHK("cxr reset", 32'h0, rd)
    `CHK("sr reset", SR_RESET, sr)
    $display("test reset done");
    for (a = 1; a < 15; a++)
    begin
      if (a > 12)
        set_sr(msr | (a == 13 ? 32'h0000_0002 : 32'h0000_0004));
      take(a);
    end
    spr(1'b0, SPR_CXR, 32'h0);
    `CHK("cxr still", 32'h0, rd)
    ret();
    `CHK("return pc", mpc, rpc)
    `CHK("return sr", psr, sr)
    $display("test entry done");
    a = 1 + $urandom % 10;
    b = a + 1 + $urandom % (11 - a);
    @(posedge clk_sys);
    {bits, post} <= {(15'(1) << a) | (15'(1) << b), 1'b1};
    @(posedge clk_sys);
    post <= 1'b0;
    wait_rv();
    `CHK("first", {20'h0, vec[a]}, rpc)
    @(posedge clk_sys);
    wait_rv();
    `CHK("second", {20'h0, vec[b]}, rpc)
    // Both winners wrote set zero; address faults among them moved the saved address
    if (a inside {1, 2, 3, 5, 6, 9, 10} || b inside {1, 2, 3, 5, 6, 9, 10})
      mea = ea;
    @(posedge clk_sys);
    {bits, post} <= {15'h0001, 1'b1};
    @(posedge clk_sys);
    post <= 1'b0;
    wait_rv();
    `CHK("reset cause", VEC_RESET, rpc)
    $display("test priority done");
    set_sr(32'h0000_0000);
    spr(1'b0, SPR_CXR, 32'h0);
    `CHK("user refused", 1'b1, err)
    take(8);
    spr(1'b0, 16'h0001, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test access done");
    set_sr(32'h0000_1001);
    spr(1'b1, SPR_CXR, 32'h0003_0000);
    msr[31:28] = 4'h3;
    `CHK("cid write", msr, sr)
    take(8);
    spr(1'b0, SPR_CXR, 32'h0);
    `CHK("cxr after", 32'h0000_0003, rd)
    spr(1'b1, SPR_CXR, 32'h0000_0004);
    spr(1'b0, SPR_EXCEPTION_PC_REG, 32'h0);
    `CHK("fresh set", mpc, rd)
    spr(1'b1, SPR_CXR, 32'h0000_0003);
    ret();
    `CHK("ctx return", mpc, rpc)
    `CHK("ctx sr", psr, sr)
    msr = psr;
    spr(1'b1, SPR_CXR, 32'h000F_0000);
    msr[31:28] = 4'hF;
    take(8);
    spr(1'b0, SPR_CXR, 32'h0);
    `CHK("ovf cxr", 32'h0, rd)
    spr(1'b1, SPR_CXR, 32'h0000_000F);
    spr(1'b0, SPR_EXCEPTION_PC_REG, 32'h0);
    `CHK("ovf set", mpc, rd)
    $display("test context done");
    test_done();
  end
endmodule
